// file: arc_atomic_checker.sv
// Atomic request checker and executor front end of the completer
`timescale 1ns/100ps
module arc_atomic_checker
    import arc_pkg::*;
(
    input wire logic core_clk, // Transaction layer clock
    input wire logic resetn, // Synchronous link reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    // Incoming atomic requests
    input wire logic req_valid, // Request offered
    output logic req_ready, // Request taken this cycle
    input wire arc_op_e req_op, // Operation type
    input wire logic [ARC_LEN_W-1:0] req_len, // Length field in dwords
    input wire logic req_poisoned, // Poisoned request
    input wire logic [ARC_FUNC_W-1:0] req_func, // Target function
    input wire logic [ARC_ADDR_W-1:0] req_addr, // Target address
    input wire logic [ARC_ID_W-1:0] req_requester_id, // Requester identity
    input wire logic [ARC_TAG_W-1:0] req_tag, // Request tag
    input wire logic [ARC_OPND_W-1:0] req_operands, // Operand payload
    // Static configuration
    input wire logic [ARC_NUM_FUNC-1:0] func_atomic_cap, // Per function completer ability
    input wire logic [ARC_NUM_FUNC-1:0] func_has_bar, // Per function memory windows
    input wire logic [ARC_CAP_W-1:0] cap_mask, // Supported {op,size} pairs
    input wire logic [ARC_ADDR_W-1:0] exec_base, // Execution window low bound
    input wire logic [ARC_ADDR_W-1:0] exec_limit, // Execution window high bound
    input wire logic vtab_en, // Vector table region present
    input wire logic [ARC_ADDR_W-1:0] vtab_base, // Vector table low bound
    input wire logic [ARC_ADDR_W-1:0] vtab_limit, // Vector table high bound
    // Target memory
    output logic mem_valid, // Operation offered to memory
    input wire logic mem_ready, // Memory takes operation
    output logic [ARC_ADDR_W-1:0] mem_addr, // Target address
    output arc_op_e mem_op, // Operation type
    output arc_size_e mem_size, // Operand size
    output logic [ARC_OPND_W-1:0] mem_operands, // Operand payload
    input wire logic mem_rsp_valid, // Memory result ready
    input wire logic mem_rsp_uncorr, // Uncorrectable error during operation
    input wire logic [ARC_RES_W-1:0] mem_rsp_data, // Original target value
    // Completions
    output logic cpl_valid, // Completion pending
    input wire logic cpl_ready, // Transmit side takes completion
    output arc_status_e cpl_status, // Completion status
    output logic cpl_has_data, // Data present
    output logic [ARC_RES_W-1:0] cpl_data, // Completion data
    output logic [ARC_LEN_W-1:0] cpl_len, // Data length in dwords
    output logic [ARC_ID_W-1:0] cpl_req_id, // Requester identity
    output logic [ARC_TAG_W-1:0] cpl_tag, // Request tag
    // Error reporting
    output logic err_malformed, // Malformed packet seen, one cycle
    output logic err_poisoned, // Poisoned request received, one cycle
    output logic err_unsup, // Unsupported request, one cycle
    output logic err_abort, // Completer abort, one cycle
    output logic busy // Request in progress
);

    // ------------------------------------------------------------------
    // Request classification
    // ------------------------------------------------------------------
    arc_size_e dec_size;
    arc_class_e dec_cls;

    arc_req_decode u_decode (
        .op(req_op),
        .len(req_len),
        .poisoned(req_poisoned),
        .func(req_func),
        .addr(req_addr),
        .func_atomic_cap(func_atomic_cap),
        .func_has_bar(func_has_bar),
        .cap_mask(cap_mask),
        .exec_base(exec_base),
        .exec_limit(exec_limit),
        .vtab_en(vtab_en),
        .vtab_base(vtab_base),
        .vtab_limit(vtab_limit),
        .size(dec_size),
        .cls(dec_cls)
    );

    // ------------------------------------------------------------------
    // State and held request
    // ------------------------------------------------------------------
    arc_state_e state_reg;
    arc_state_e state_next;
    logic [ARC_ID_W-1:0] id_reg;
    logic [ARC_TAG_W-1:0] tag_reg;
    logic [ARC_LEN_W-1:0] len_reg;

    wire in_idle = (state_reg == ARC_ST_IDLE);
    wire accept = ce && req_valid && in_idle;
    wire cls_exec = (dec_cls == ARC_CL_EXEC);
    wire cls_mal = (dec_cls == ARC_CL_MALFORMED);
    wire cls_poison = (dec_cls == ARC_CL_POISON);
    wire cls_unsup = (dec_cls == ARC_CL_UNSUP);
    wire cls_abort = (dec_cls == ARC_CL_ABORT);
    wire mem_taken = ce && (state_reg == ARC_ST_MEM) && mem_ready;
    wire mem_done = ce && (state_reg == ARC_ST_WAIT) && mem_rsp_valid;
    wire mem_fail = mem_done && mem_rsp_uncorr;
    wire cpl_sent = ce && (state_reg == ARC_ST_CPL) && cpl_valid && cpl_ready;

    // Only a request cleared of every check is handed to memory, so a poisoned
    // request can never reach the target, not even as a partial write
    wire start_exec = accept && cls_exec;
    // Poisoned, unsupported and aborted requests skip memory and go straight to a completion
    wire early_cpl = accept && (cls_poison || cls_unsup || cls_abort);

    assign req_ready = ce && in_idle;
    assign mem_valid = (state_reg == ARC_ST_MEM);
    assign busy = !in_idle;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ARC_ST_IDLE:
            begin
                if (start_exec)
                    state_next = ARC_ST_MEM;
                else if (early_cpl)
                    state_next = ARC_ST_CPL;
            end
            ARC_ST_MEM:
            begin
                if (mem_taken)
                    state_next = ARC_ST_WAIT;
            end
            ARC_ST_WAIT:
            begin
                if (mem_done)
                    state_next = ARC_ST_CPL;
            end
            ARC_ST_CPL:
            begin
                if (cpl_sent)
                    state_next = ARC_ST_IDLE;
            end
            default:
                state_next = ARC_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            state_reg <= ARC_ST_IDLE;
        else if (ce)
            state_reg <= state_next;
    end

    // ------------------------------------------------------------------
    // Held request fields and memory command
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            id_reg <= '0;
            tag_reg <= '0;
            len_reg <= '0;
        end
        else if (accept)
        begin
            id_reg <= req_requester_id;
            tag_reg <= req_tag;
            len_reg <= req_len;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            mem_addr <= '0;
            mem_op <= ARC_OP_FETCHADD;
            mem_size <= ARC_SZ_32;
            mem_operands <= '0;
        end
        else if (start_exec)
        begin
            mem_addr <= req_addr;
            mem_op <= req_op;
            mem_size <= dec_size;
            mem_operands <= req_operands;
        end
    end

    // ------------------------------------------------------------------
    // Completion build
    // ------------------------------------------------------------------
    // Result data is as long as the request payload, except compare-and-swap
    // which returns one operand out of two
    wire [ARC_LEN_W-1:0] ret_len = (mem_op == ARC_OP_CAS) ? (len_reg >> 1) : len_reg;
    wire cpl_load = early_cpl || mem_done;
    wire [ARC_ID_W-1:0] ld_id = accept ? req_requester_id : id_reg;
    wire [ARC_TAG_W-1:0] ld_tag = accept ? req_tag : tag_reg;
    wire ld_data = mem_done && !mem_rsp_uncorr;
    // No undo of a partly updated target after an uncorrectable error
    arc_status_e ld_status;
    assign ld_status = (accept && cls_abort) ? ARC_CPL_CA
        : accept ? ARC_CPL_UR
        : mem_rsp_uncorr ? ARC_CPL_CA
        : ARC_CPL_SC;

    arc_cpl_gen u_cpl (
        .core_clk(core_clk),
        .resetn(resetn),
        .ce(ce),
        .load(cpl_load),
        .status(ld_status),
        .has_data(ld_data),
        .data(mem_rsp_data),
        .len(ret_len),
        .req_id(ld_id),
        .tag(ld_tag),
        .cpl_ready(cpl_ready),
        .cpl_valid(cpl_valid),
        .cpl_status(cpl_status),
        .cpl_has_data(cpl_has_data),
        .cpl_data(cpl_data),
        .cpl_len(cpl_len),
        .cpl_req_id(cpl_req_id),
        .cpl_tag(cpl_tag)
    );

    // ------------------------------------------------------------------
    // Error pulses
    // ------------------------------------------------------------------
    // Malformed requests only raise the error; they never produce a completion
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            err_malformed <= 1'b0;
            err_poisoned <= 1'b0;
            err_unsup <= 1'b0;
            err_abort <= 1'b0;
        end
        else if (ce)
        begin
            err_malformed <= accept && cls_mal;
            err_poisoned <= accept && cls_poison;
            err_unsup <= accept && cls_unsup;
            err_abort <= (accept && cls_abort) || mem_fail;
        end
    end

endmodule

// file: arc_atomic_checker_tb_top.sv
// Self-checking bench for the atomic request checker
`timescale 1ns/100ps
module arc_atomic_checker_tb_top
    import arc_pkg::*;
;
    logic core_clk, resetn, ce, req_valid, req_ready, req_poisoned, vtab_en, busy;
    logic mem_valid, mem_ready, mem_rsp_valid, mem_rsp_uncorr, cpl_valid, cpl_ready;
    logic cpl_has_data, err_malformed, err_poisoned, err_unsup, err_abort, slow, inj_uncorr;
    arc_op_e req_op, mem_op;
    arc_size_e mem_size;
    arc_status_e cpl_status;
    logic [ARC_LEN_W-1:0] req_len, cpl_len;
    logic [ARC_FUNC_W-1:0] req_func;
    logic [ARC_ADDR_W-1:0] req_addr, mem_addr, exec_base, exec_limit, vtab_base, vtab_limit;
    logic [ARC_ID_W-1:0] req_requester_id, cpl_req_id;
    logic [ARC_TAG_W-1:0] req_tag, cpl_tag;
    logic [ARC_OPND_W-1:0] req_operands, mem_operands;
    logic [ARC_NUM_FUNC-1:0] func_atomic_cap, func_has_bar;
    logic [ARC_CAP_W-1:0] cap_mask;
    logic [ARC_RES_W-1:0] mem_rsp_data, cpl_data;
    int op_count, miscompares, n_checks, seed, i, j;
    logic ce_rand;
    logic [9:0] lens [6] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h008};

    arc_atomic_checker dut_u (.*);
    arc_mem_model mem_u (.*);

    initial
    begin
        core_clk = 0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic complete_run;
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_cpl(input logic [167:0] got, input logic [167:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t completion %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_err(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t malformed flags %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_mem(input int got, input int exp);
        n_checks++;
        if (got != exp)
        begin
            miscompares++;
            $display("[FAIL] %0t memory ops %0d expected %0d", $time, got, exp);
        end
    endtask

    // 1 malformed, 2 poisoned, 3 unsupported, 4 abort, 0 execute
    function automatic int classify(logic [1:0] op, logic [9:0] len, logic poi, logic [2:0] fn,
        logic [63:0] ad);
        int sz;
        if (op == 2 ? !(len == 2 || len == 4 || len == 8) :
            op == 3 ? !(len == 1 || len == 2 || len == 4 || len == 8) : !(len == 1 || len == 2))
            return 1;
        if (poi)
            return 2;
        sz = (op == 2) ? ((len == 2) ? 0 : (len == 4) ? 1 : 2) : ((len == 1) ? 0 : 1);
        if (!func_atomic_cap[fn] || !func_has_bar[fn] || op == 3 || !cap_mask[op * 4 + sz])
            return 3;
        if (ad < exec_base || ad > exec_limit || (vtab_en && ad >= vtab_base && ad <= vtab_limit))
            return 4;
        return 0;
    endfunction

    task automatic do_req(input logic [1:0] op, input logic [9:0] len, input logic poi,
        input logic [2:0] fn, input logic [63:0] ad);
        int cls, ops0, n;
        logic hs;
        logic [9:0] el;
        logic [127:0] mk;
        logic [167:0] got;
        logic [2:0] st;
        ops0 = op_count;
        inj_uncorr = ($random(seed) & 7) == 0;
        slow = $random(seed);
        req_op = arc_op_e'(op);
        req_len = len;
        req_poisoned = poi;
        req_func = fn;
        req_addr = ad;
        req_tag = $random(seed);
        req_requester_id = $random(seed);
        req_operands = {8{$random(seed)}};
        req_valid = 1;
        hs = 0;
        for (n = 0; n < 100 && !hs; n++)
        begin
            @(negedge core_clk);
            hs = req_ready;
            @(posedge core_clk) #10;
        end
        req_valid = 0;
        req_addr = ~req_addr;
        req_operands = ~req_operands;
        cls = classify(op, len, poi, fn, ad);
        if (cls == 1)
        begin
            @(negedge core_clk);
            chk_err({err_malformed, cpl_valid}, 2'b10);
            @(posedge core_clk) #10;
        end
        else
        begin
            el = (cls != 0 || inj_uncorr) ? 10'h000 : (op == 2) ? len >> 1 : len;
            mk = (el == 1) ? 128'hffffffff : (el == 2) ? {64'h0, {64{1'b1}}} : {128{1'b1}};
            st = (cls == 2 || cls == 3) ? 3'b001 : (cls == 4 || inj_uncorr) ? 3'b100 : 3'b000;
            hs = 0;
            for (n = 0; n < 200 && !hs; n++)
            begin
                cpl_ready = $random(seed);
                @(negedge core_clk);
                hs = cpl_valid && cpl_ready && ce;
                got = {cpl_status, cpl_has_data, cpl_data & mk, cpl_len, cpl_req_id, cpl_tag};
                @(posedge core_clk) #10;
            end
            cpl_ready = 0;
            chk_cpl(got, {st, el != 0, (el != 0) ? {4{ad[31:0] ^ 32'(ops0)}} & mk : 128'h0, el,
                req_requester_id, req_tag});
        end
        chk_mem(op_count, ops0 + ((cls == 0) ? 1 : 0));
    endtask

    initial
    begin
        ce = 1;
        forever
        begin
            @(posedge core_clk) #10;
            if (ce_rand)
                ce = ($random(seed) & 7) != 0;
        end
    end

    // 325 requests of at most 61 cycles each
    initial
    begin
        #(100 * 20000);
        miscompares++;
        complete_run;
    end

    initial
    begin
        seed = 32'hea1251c2;
        miscompares = 0;
        n_checks = 0;
        ce_rand = 0;
        resetn = 0;
        {req_valid, req_poisoned, cpl_ready, slow, inj_uncorr} = '0;
        req_op = ARC_OP_FETCHADD;
        {req_len, req_func, req_addr, req_tag, req_requester_id, req_operands} = '0;
        func_atomic_cap = 8'h7f;
        func_has_bar = 8'hbf;
        cap_mask = 16'h0333;
        exec_base = 64'h1000;
        exec_limit = 64'h1fff;
        vtab_en = 1;
        vtab_base = 64'h1800;
        vtab_limit = 64'h18ff;
        repeat (16) @(posedge core_clk);
        #10;
        resetn = 1;
        for (i = 0; i < 4; i++)
            for (j = 0; j < 6; j++)
                do_req(i, lens[j], 0, 0, 64'h1100);
        do_req(0, 1, 1, 0, 64'h1100);
        ce_rand = 1;
        for (i = 0; i < 300; i++)
        begin
            if (i == 150)
            begin
                cap_mask = 16'hffff;
                vtab_en = 0;
                func_atomic_cap = 8'hff;
            end
            // Some lengths broken on purpose
            do_req($random(seed), lens[{$random(seed)} % 6], ($random(seed) & 7) == 0,
                $random(seed), 64'h800 + ({$random(seed)} & 32'h1fff));
        end
        complete_run;
    end
endmodule

// file: arc_chk.sv
// Port-level assertions for the atomic request checker
`timescale 1ns/100ps
module arc_chk
    import arc_pkg::*;
(
    input wire logic core_clk, resetn, ce, // Clock, reset, enable
    input wire logic req_valid, req_ready, req_poisoned, // Request handshake
    input wire arc_op_e req_op, // Operation
    input wire logic [ARC_LEN_W-1:0] req_len, // Length
    input wire logic [ARC_FUNC_W-1:0] req_func, // Function
    input wire logic [ARC_ADDR_W-1:0] req_addr, mem_addr, // Addresses
    input wire logic [ARC_NUM_FUNC-1:0] func_atomic_cap, func_has_bar, // Function masks
    input wire logic [ARC_CAP_W-1:0] cap_mask, // Supported pairs
    input wire logic [ARC_ADDR_W-1:0] exec_base, exec_limit, vtab_base, vtab_limit, // Windows
    input wire logic vtab_en, mem_valid, mem_rsp_valid, mem_rsp_uncorr, // Memory side
    input wire logic cpl_valid, cpl_ready, cpl_has_data, // Completion
    input wire arc_status_e cpl_status, // Status
    input wire logic [ARC_TAG_W-1:0] cpl_tag, // Tag
    input wire logic err_malformed, err_poisoned, err_unsup, err_abort, busy // Flags
);
    wire take = req_valid && req_ready && ce;
    wire l1 = req_len == ARC_LEN_1DW;
    wire l2 = req_len == ARC_LEN_2DW;
    wire l4 = req_len == ARC_LEN_4DW;
    wire l8 = req_len == ARC_LEN_8DW;
    wire is_cas = req_op == ARC_OP_CAS;
    wire is_rsv = req_op == ARC_OP_RSVD;
    wire len_bad = is_cas ? !(l2 || l4 || l8) : is_rsv ? !(l1 || l2 || l4 || l8) : !(l1 || l2);
    wire [1:0] sz = is_cas ? (l2 ? 2'b00 : l4 ? 2'b01 : 2'b10) : (l1 ? 2'b00 : 2'b01);
    wire [3:0] cidx = {req_op, sz};
    wire unsup = !func_atomic_cap[req_func] || !func_has_bar[req_func] || is_rsv || !cap_mask[cidx];
    wire outside = req_addr < exec_base || req_addr > exec_limit
        || (vtab_en && req_addr >= vtab_base && req_addr <= vtab_limit);
    wire good = take && !len_bad && !req_poisoned;
    // Memory result seen in the wait state
    wire rsp = busy && !mem_valid && !cpl_valid && mem_rsp_valid && ce;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_cpl_st(arc_status_e st);
        cpl_valid && cpl_status == st && !cpl_has_data && !mem_valid;
    endsequence

    a_bad_len_dropped: assert property (take && len_bad |=> err_malformed && !cpl_valid)
        else $error("malformed request answered");
    a_formed_not_bad: assert property (take && !len_bad |=> !err_malformed)
        else $error("well formed request flagged malformed");
    a_poison_unsup: assert property (take && !len_bad && req_poisoned |=> err_poisoned ##0 s_cpl_st(ARC_CPL_UR))
        else $error("poisoned request not answered unsupported");
    a_unsup_status: assert property (good && unsup |=> err_unsup ##0 s_cpl_st(ARC_CPL_UR))
        else $error("unsupported request not answered unsupported");
    a_window_abort: assert property (good && !unsup && outside |=> err_abort ##0 s_cpl_st(ARC_CPL_CA))
        else $error("request outside window not aborted");
    a_exec_issue: assert property (good && !unsup && !outside |=> mem_valid && !cpl_valid && mem_addr == $past(req_addr))
        else $error("supported request not sent to memory");
    a_uncorr_abort: assert property (rsp && mem_rsp_uncorr |=> err_abort ##0 s_cpl_st(ARC_CPL_CA))
        else $error("memory error not aborted");
    a_exec_success: assert property (rsp && !mem_rsp_uncorr |=> cpl_valid && cpl_status == ARC_CPL_SC && cpl_has_data)
        else $error("executed request not completed");
    a_cpl_hold: assert property (cpl_valid && !(cpl_ready && ce) |=> cpl_valid && $stable(cpl_tag) && $stable(cpl_status))
        else $error("completion changed before taken");
    a_cpl_single: assert property (cpl_valid && cpl_ready && ce |=> !cpl_valid && !busy)
        else $error("completion repeated");
endmodule

bind arc_atomic_checker arc_chk chk_u (.*);

// file: arc_cpl_gen.sv
// Completion holding register toward the transmit side
`timescale 1ns/100ps
module arc_cpl_gen
    import arc_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic load, // Capture a new completion
    input wire arc_status_e status, // Status to send
    input wire logic has_data, // Completion carries data
    input wire logic [ARC_RES_W-1:0] data, // Returned data
    input wire logic [ARC_LEN_W-1:0] len, // Returned length in dwords
    input wire logic [ARC_ID_W-1:0] req_id, // Original requester
    input wire logic [ARC_TAG_W-1:0] tag, // Original tag
    input wire logic cpl_ready, // Transmit side takes completion
    output logic cpl_valid, // Completion pending
    output arc_status_e cpl_status, // Completion status
    output logic cpl_has_data, // Data present
    output logic [ARC_RES_W-1:0] cpl_data, // Completion data
    output logic [ARC_LEN_W-1:0] cpl_len, // Data length in dwords
    output logic [ARC_ID_W-1:0] cpl_req_id, // Requester identity
    output logic [ARC_TAG_W-1:0] cpl_tag // Request tag
);

    wire take = ce && load;
    wire sent = ce && cpl_valid && cpl_ready;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            cpl_valid <= 1'b0;
        else if (take)
            cpl_valid <= 1'b1;
        else if (sent)
            cpl_valid <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            cpl_status <= ARC_CPL_SC;
            cpl_has_data <= 1'b0;
            cpl_data <= '0;
            cpl_len <= '0;
            cpl_req_id <= '0;
            cpl_tag <= '0;
        end
        else if (take)
        begin
            cpl_status <= status;
            cpl_has_data <= has_data;
            cpl_data <= has_data ? data : '0;
            cpl_len <= has_data ? len : '0;
            cpl_req_id <= req_id;
            cpl_tag <= tag;
        end
    end

endmodule

// file: arc_mem_model.sv
// Target memory model on the completer's operation port
`timescale 1ns/100ps
module arc_mem_model
    import arc_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic resetn, // Reset, active low
    input wire logic ce, // Completer clock enable
    input wire logic mem_valid, // Operation offered
    input wire logic [ARC_ADDR_W-1:0] mem_addr, // Target address
    input wire logic slow, // Stall and delay answers
    input wire logic inj_uncorr, // Answer with an error
    output logic mem_ready, // Operation taken
    output logic mem_rsp_valid, // Result
    output logic mem_rsp_uncorr, // Error flag
    output logic [ARC_RES_W-1:0] mem_rsp_data, // Original value
    output int op_count // Operations carried out
);
    logic hs;
    logic took;
    logic [31:0] addr_l;
    int left;
    initial
    begin
        {mem_ready, mem_rsp_valid, mem_rsp_uncorr} = '0;
        mem_rsp_data = '0;
        op_count = 0;
        left = 0;
        forever
        begin
            @(negedge core_clk);
            hs = mem_valid && mem_ready && ce;
            took = mem_rsp_valid && ce;
            @(posedge core_clk) #10;
            // Held until taken; idle lines show changing data
            if (!mem_rsp_valid || took || !resetn)
            begin
                mem_rsp_valid = 0;
                mem_rsp_data = ~mem_rsp_data;
                mem_rsp_uncorr = ~mem_rsp_uncorr;
            end
            if (hs)
            begin
                addr_l = mem_addr[31:0];
                left = slow ? 3 : 1;
            end
            if (!resetn)
                left = 0;
            if (left == 1)
            begin
                mem_rsp_valid = 1;
                mem_rsp_uncorr = inj_uncorr;
                mem_rsp_data = {4{addr_l ^ 32'(op_count)}};
                op_count++;
            end
            if (left > 0)
                left--;
            mem_ready = slow ? ~mem_ready : 1'b1;
        end
    end
endmodule

// file: arc_pkg.sv
// Constants and types shared by the atomic request completer checks
package arc_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ARC_LEN_W = 10;
    localparam int ARC_ADDR_W = 64;
    localparam int ARC_FUNC_W = 3;
    localparam int ARC_NUM_FUNC = 8;
    localparam int ARC_ID_W = 16;
    localparam int ARC_TAG_W = 10;
    localparam int ARC_OPND_W = 256;
    localparam int ARC_RES_W = 128;
    localparam int ARC_CAP_W = 16;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ARC_OP_FETCHADD = 2'b00,
        ARC_OP_SWAP = 2'b01,
        ARC_OP_CAS = 2'b10,
        ARC_OP_RSVD = 2'b11
    } arc_op_e;

    typedef enum logic [1:0] {
        ARC_SZ_32 = 2'b00,
        ARC_SZ_64 = 2'b01,
        ARC_SZ_128 = 2'b10,
        ARC_SZ_NONE = 2'b11
    } arc_size_e;

    // Length field values in dwords
    localparam logic [ARC_LEN_W-1:0] ARC_LEN_1DW = 10'h001;
    localparam logic [ARC_LEN_W-1:0] ARC_LEN_2DW = 10'h002;
    localparam logic [ARC_LEN_W-1:0] ARC_LEN_4DW = 10'h004;
    localparam logic [ARC_LEN_W-1:0] ARC_LEN_8DW = 10'h008;

    typedef enum logic [2:0] {
        ARC_CPL_SC = 3'b000,
        ARC_CPL_UR = 3'b001,
        ARC_CPL_CA = 3'b100
    } arc_status_e;

    typedef enum logic [2:0] {
        ARC_CL_EXEC = 3'b000,
        ARC_CL_MALFORMED = 3'b001,
        ARC_CL_POISON = 3'b010,
        ARC_CL_UNSUP = 3'b011,
        ARC_CL_ABORT = 3'b100
    } arc_class_e;

    typedef enum logic [1:0] {
        ARC_ST_IDLE = 2'b00,
        ARC_ST_MEM = 2'b01,
        ARC_ST_WAIT = 2'b10,
        ARC_ST_CPL = 2'b11
    } arc_state_e;

endpackage

// file: arc_req_decode.sv
// Combinational classifier for one atomic read-modify-write request
`timescale 1ns/100ps
module arc_req_decode
    import arc_pkg::*;
(
    input wire arc_op_e op, // Operation type
    input wire logic [ARC_LEN_W-1:0] len, // Length field in dwords
    input wire logic poisoned, // Request is poisoned
    input wire logic [ARC_FUNC_W-1:0] func, // Target function
    input wire logic [ARC_ADDR_W-1:0] addr, // Target address
    input wire logic [ARC_NUM_FUNC-1:0] func_atomic_cap, // Function can complete atomics
    input wire logic [ARC_NUM_FUNC-1:0] func_has_bar, // Function has memory windows
    input wire logic [ARC_CAP_W-1:0] cap_mask, // Supported {op,size} pairs
    input wire logic [ARC_ADDR_W-1:0] exec_base, // Execution window low bound
    input wire logic [ARC_ADDR_W-1:0] exec_limit, // Execution window high bound
    input wire logic vtab_en, // Vector table region present
    input wire logic [ARC_ADDR_W-1:0] vtab_base, // Vector table low bound
    input wire logic [ARC_ADDR_W-1:0] vtab_limit, // Vector table high bound
    output arc_size_e size, // Operand size
    output arc_class_e cls // Outcome class
);

    // ------------------------------------------------------------------
    // Operand size from length
    // ------------------------------------------------------------------
    wire is_cas = (op == ARC_OP_CAS);
    wire sz32 = is_cas ? (len == ARC_LEN_2DW) : (len == ARC_LEN_1DW);
    wire sz64 = is_cas ? (len == ARC_LEN_4DW) : (len == ARC_LEN_2DW);
    wire sz128 = is_cas && (len == ARC_LEN_8DW);
    // A reserved op has no defined size; judge its length against all legal values
    wire len_any = (len == ARC_LEN_1DW) || (len == ARC_LEN_2DW)
        || (len == ARC_LEN_4DW) || (len == ARC_LEN_8DW);
    wire len_ok = (op == ARC_OP_RSVD) ? len_any : (sz32 || sz64 || sz128);

    assign size = sz32 ? ARC_SZ_32 : sz64 ? ARC_SZ_64 : sz128 ? ARC_SZ_128 : ARC_SZ_NONE;

    // ------------------------------------------------------------------
    // Support and address checks
    // ------------------------------------------------------------------
    wire [3:0] cap_idx = {op, size};
    wire func_ok = func_atomic_cap[func] && func_has_bar[func];
    wire type_ok = (op != ARC_OP_RSVD) && (size != ARC_SZ_NONE) && cap_mask[cap_idx];
    wire in_win = (addr >= exec_base) && (addr <= exec_limit);
    wire in_vtab = vtab_en && (addr >= vtab_base) && (addr <= vtab_limit);

    // Precedence: malformed, poisoned, unsupported, abort, execute
    assign cls = !len_ok ? ARC_CL_MALFORMED
        : poisoned ? ARC_CL_POISON
        : !(func_ok && type_ok) ? ARC_CL_UNSUP
        : (!in_win || in_vtab) ? ARC_CL_ABORT
        : ARC_CL_EXEC;

endmodule
